/* File: pkg/csoc_pkg.sv */
/*
 package of the ccd sample and offset control block: register addresses,
 field positions, reset values and timing counts.
 assumes a single 40 mhz clock domain.
*/
`default_nettype none
package csoc_pkg;
   localparam int CLK_MHZ = 40;
   // serial word: 4 address bits then 8 data bits
   localparam int SER_BITS = 12;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] ADDR_CLOCK = 4'h3;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_FINE_HIGH = 4'h6;
   localparam logic [3:0] ADDR_FINE_LOW = 4'h7;
   localparam logic [3:0] ADDR_COARSE = 4'h8;
   localparam logic [3:0] ADDR_CHIP_RESET = 4'hf;
   localparam logic [7:0] CLOCK_RST = 8'h10;
   localparam logic [7:0] CONTROL_RST = 8'h01;
   localparam logic [7:0] FINE_HIGH_RST = 8'h00;
   localparam logic [1:0] FINE_LOW_RST = 2'h0;
   localparam logic [3:0] COARSE_RST = 4'h0;
   // clock register fields
   localparam int CK_CAL_POL = 0;
   localparam int CK_CLAMP_POL = 1;
   localparam int CK_VIDEO_POL = 2;
   localparam int CK_BLACK_POL = 3;
   localparam int CK_CLAMP_OPT = 4;
   localparam int CK_RST_REJ = 6;
   // control and reset register fields
   localparam int CT_OE = 0;
   localparam int CT_PD = 1;
   localparam int RS_BIT = 0;
   // reset noise reject window, longest time, rounds down
   localparam int RNR_NS = 50;
   localparam int RNR_CYC = (RNR_NS * CLK_MHZ) / 1000;
   localparam int PIX_W = 10;
   localparam int FIFO_D = 16;
   // synchronised pin indices
   localparam int PIN_SCLK = 0;
   localparam int PIN_LOAD = 1;
   localparam int PIN_SDI = 2;
   localparam int PIN_BLK = 3;
   localparam int PIN_VID = 4;
   localparam int PIN_CLAMP = 5;
   localparam int PIN_CAL = 6;
   localparam int NPINS = 7;
endpackage : csoc_pkg
`default_nettype wire

/* File: hdl/csoc_fifo.sv */
/*
 synchronous fifo with valid/ready on both sides.
 assumes one clock and a synchronous active high reset.
*/
`default_nettype none
module csoc_fifo #(
   parameter int W = 10,
   parameter int D = 16
) (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic in_valid, // write request
   output logic in_ready, // room available
   input wire logic [W-1:0] in_data, // write word
   output logic out_valid, // word available
   input wire logic out_ready, // read accept
   output logic [W-1:0] out_data // head word
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // honest full and empty from the occupancy count
   assign in_ready = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
   // pointers and count
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : csoc_fifo
`default_nettype wire

/* File: hdl/csoc_top.sv */
/*
 ccd sample and offset control: serial register port, pixel sampling
 phases, reset noise reject and the pixel output word.
 assumes pins arrive asynchronously and adc_code is on clk.
*/
`default_nettype none
module csoc_top (
   input wire logic clk, // 40 mhz clock
   input wire logic sys_rst, // sync reset, active high
   input wire logic serial_clk, // serial shift clock pin
   input wire logic serial_load_n, // serial latch pin, low to shift
   input wire logic serial_data_in, // serial data pin
   input wire logic black_sample_strobe, // black level strobe pin
   input wire logic video_sample_strobe, // video level strobe pin
   input wire logic clamp_strobe, // line clamp strobe pin
   input wire logic cal_strobe, // calibration strobe pin
   input wire logic [csoc_pkg::PIX_W-1:0] adc_code, // converter result
   input wire logic pixel_ready, // consumer takes pixel_out
   output logic [csoc_pkg::PIX_W-1:0] pixel_out, // pixel output word
   output logic pixel_valid, // pixel_out holds a word
   output logic fifo_ready, // pixel buffer has room
   output logic black_phase, // black sample switch phase
   output logic video_phase, // video sample switch phase
   output logic dc_restore, // dc restore switch
   output logic reset_noise_reject, // high opens input switches
   output logic cal_active, // calibration gate
   output logic [9:0] fine_offset_code, // fine offset dac code
   output logic [3:0] coarse_offset_code, // coarse offset dac code
   output logic power_down_bit, // power down request
   output logic outputs_enable // output drivers on
);
   import csoc_pkg::*;

   // two-flop synchronisers, one per pin
   logic [NPINS-1:0] pin_raw;
   logic [NPINS-1:0] meta_r;
   logic [NPINS-1:0] pin_s;
   logic [NPINS-1:0] pin_d_r;
   assign pin_raw = {cal_strobe, clamp_strobe, video_sample_strobe,
                     black_sample_strobe, serial_data_in, serial_load_n,
                     serial_clk};
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            meta_r[gi] <= pin_raw[gi];
            pin_s[gi] <= meta_r[gi];
            pin_d_r[gi] <= pin_s[gi];
         end
      end
   endgenerate

   // serial port edge decode
   wire sclk_rise = pin_s[PIN_SCLK] && !pin_d_r[PIN_SCLK];
   wire load_rise = pin_s[PIN_LOAD] && !pin_d_r[PIN_LOAD];
   wire shifting = !pin_s[PIN_LOAD];
   logic [SER_BITS-1:0] shift_r;
   logic [4:0] bitcnt_r;
   // shift msb first while latch is low; count bits of this word
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shift_r <= '0;
         bitcnt_r <= '0;
      end else if (shifting && sclk_rise) begin
         shift_r <= {shift_r[SER_BITS-2:0], pin_s[PIN_SDI]};
         // saturate at all ones so an over-long word never reads as twelve
         if (bitcnt_r != '1) bitcnt_r <= bitcnt_r + 5'h1;
      end else if (load_rise) begin
         bitcnt_r <= '0;
      end
   end

   // commit decode: only a full word is taken
   wire wr = load_rise && (bitcnt_r == 5'(SER_BITS));
   wire [ADDR_W-1:0] wr_addr = shift_r[SER_BITS-1:DATA_W];
   wire [DATA_W-1:0] wr_data = shift_r[DATA_W-1:0];
   wire wr_clock = wr && (wr_addr == ADDR_CLOCK);
   wire wr_ctrl = wr && (wr_addr == ADDR_CONTROL);
   wire wr_fhi = wr && (wr_addr == ADDR_FINE_HIGH);
   wire wr_flo = wr && (wr_addr == ADDR_FINE_LOW);
   wire wr_coarse = wr && (wr_addr == ADDR_COARSE);
   wire wr_reset = wr && (wr_addr == ADDR_CHIP_RESET)
                   && wr_data[RS_BIT];

   // chip reset pulse from the reset register
   logic soft_rst_r;
   always_ff @(posedge clk) begin
      if (sys_rst) soft_rst_r <= 1'b0;
      else soft_rst_r <= wr_reset;
   end
   wire rst_all = sys_rst || soft_rst_r;

   // register array; power down never touches it
   logic [7:0] clock_r;
   logic [7:0] ctrl_r;
   logic [7:0] fhi_stage_r;
   logic [1:0] flo_stage_r;
   logic hi_seen_r;
   logic lo_seen_r;
   logic [9:0] fine_r;
   logic [3:0] coarse_r;
   always_ff @(posedge clk) begin
      if (rst_all) begin
         clock_r <= CLOCK_RST;
         ctrl_r <= CONTROL_RST;
         coarse_r <= COARSE_RST;
      end else begin
         if (wr_clock) clock_r <= {1'b0, wr_data[6:0]};
         if (wr_ctrl) ctrl_r <= {4'h0, wr_data[3:0]};
         if (wr_coarse) coarse_r <= wr_data[3:0];
      end
   end

   // fine code halves are staged and applied together
   wire both_seen = (hi_seen_r || wr_fhi) && (lo_seen_r || wr_flo);
   always_ff @(posedge clk) begin
      if (rst_all) begin
         fhi_stage_r <= FINE_HIGH_RST;
         flo_stage_r <= FINE_LOW_RST;
         hi_seen_r <= 1'b0;
         lo_seen_r <= 1'b0;
         fine_r <= {FINE_HIGH_RST, FINE_LOW_RST};
      end else begin
         if (wr_fhi) fhi_stage_r <= wr_data;
         if (wr_flo) flo_stage_r <= wr_data[1:0];
         if (both_seen) begin
            fine_r <= {wr_fhi ? wr_data : fhi_stage_r,
                       wr_flo ? wr_data[1:0] : flo_stage_r};
            hi_seen_r <= 1'b0;
            lo_seen_r <= 1'b0;
         end else begin
            hi_seen_r <= hi_seen_r || wr_fhi;
            lo_seen_r <= lo_seen_r || wr_flo;
         end
      end
   end

   // strobe polarity: bit 0 means active low
   wire black_act = clock_r[CK_BLACK_POL] ? pin_s[PIN_BLK]
                                          : !pin_s[PIN_BLK];
   wire video_act = clock_r[CK_VIDEO_POL] ? pin_s[PIN_VID]
                                          : !pin_s[PIN_VID];
   wire clamp_pin = clock_r[CK_CLAMP_POL] ? pin_s[PIN_CLAMP]
                                          : !pin_s[PIN_CLAMP];
   wire cal_act = clock_r[CK_CAL_POL] ? pin_s[PIN_CAL]
                                      : !pin_s[PIN_CAL];
   // in cal-only mode the cal strobe also clamps
   wire clamp_act = clock_r[CK_CLAMP_OPT] ? clamp_pin : cal_act;
   wire rej_en = clock_r[CK_RST_REJ];

   // switch phases
   logic black_ph_r;
   logic video_ph_r;
   logic dc_r;
   logic cal_r;
   always_ff @(posedge clk) begin
      if (rst_all) begin
         black_ph_r <= 1'b0;
         video_ph_r <= 1'b0;
         dc_r <= 1'b0;
         cal_r <= 1'b0;
      end else begin
         black_ph_r <= black_act;
         video_ph_r <= video_act;
         dc_r <= clamp_act && video_act;
         cal_r <= cal_act;
      end
   end
   wire video_fall = video_ph_r && !video_act;

   // reset noise reject: open after video sample, close before black
   logic rnr_r;
   logic [7:0] rnr_cnt_r;
   wire rnr_done = (rnr_cnt_r == 8'(RNR_CYC - 1));
   always_ff @(posedge clk) begin
      if (rst_all || !rej_en) begin
         rnr_r <= 1'b0;
         rnr_cnt_r <= '0;
      end else if (video_fall) begin
         rnr_r <= 1'b1;
         rnr_cnt_r <= '0;
      end else if (rnr_r && (black_act || rnr_done)) begin
         rnr_r <= 1'b0;
      end else if (rnr_r) begin
         rnr_cnt_r <= rnr_cnt_r + 8'h1;
      end
   end

   // pixel buffer fed on the falling edge of the video phase
   logic fifo_in_rdy;
   logic fifo_out_vld;
   logic [PIX_W-1:0] fifo_out_data;
   logic pix_vld_r;
   logic [PIX_W-1:0] pix_r;
   logic fifo_rdy_r;
   wire take = fifo_out_vld && (!pix_vld_r || pixel_ready);
   csoc_fifo #(.W(PIX_W), .D(FIFO_D)) csoc_fifo_inst (
      .clk(clk),
      .rst(rst_all),
      .in_valid(video_fall),
      .in_ready(fifo_in_rdy),
      .in_data(adc_code),
      .out_valid(fifo_out_vld),
      .out_ready(take),
      .out_data(fifo_out_data)
   );
   // output word register
   always_ff @(posedge clk) begin
      if (rst_all) begin
         pix_r <= '0;
         pix_vld_r <= 1'b0;
         fifo_rdy_r <= 1'b0;
      end else begin
         if (take) pix_r <= fifo_out_data;
         if (take) pix_vld_r <= 1'b1;
         else if (pixel_ready) pix_vld_r <= 1'b0;
         fifo_rdy_r <= fifo_in_rdy;
      end
   end

   // outputs straight from flip-flops
   assign pixel_out = pix_r;
   assign pixel_valid = pix_vld_r;
   assign fifo_ready = fifo_rdy_r;
   assign black_phase = black_ph_r;
   assign video_phase = video_ph_r;
   assign dc_restore = dc_r;
   assign reset_noise_reject = rnr_r;
   assign cal_active = cal_r;
   assign fine_offset_code = fine_r;
   assign coarse_offset_code = coarse_r;
   assign power_down_bit = ctrl_r[CT_PD];
   assign outputs_enable = ctrl_r[CT_OE];

   // checks
   localparam int RNR_MAX = RNR_CYC;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_commit_word;
      wr_reset ##1 soft_rst_r;
   endsequence
   sequence s_video_end;
      video_ph_r && !video_act && rej_en && !rst_all;
   endsequence
   dc_restore_and_a: assert property (
      dc_r == (video_ph_r && $past(clamp_act)))
      else $error("dc restore not clamp and video");
   black_follow_a: assert property (
      !rst_all |=> black_ph_r == $past(black_act))
      else $error("black phase does not follow strobe");
   video_follow_a: assert property (
      !rst_all |=> video_ph_r == $past(video_act))
      else $error("video phase does not follow strobe");
   rnr_open_a: assert property (
      s_video_end |=> rnr_r)
      else $error("reject not opened after video");
   rnr_close_a: assert property (
      rnr_r |-> ##[1:RNR_MAX] !rnr_r)
      else $error("reject held open too long");
   rnr_off_a: assert property (
      !rej_en |=> !rnr_r)
      else $error("reject opened while disabled");
   chip_reset_a: assert property (
      s_commit_word |=> coarse_r == COARSE_RST && fine_r == '0)
      else $error("chip reset left a register");
   pd_keeps_a: assert property (
      wr_ctrl && !rst_all |=> $stable(coarse_r) && $stable(fine_r))
      else $error("power down write changed offsets");
   fine_pair_a: assert property (
      $changed(fine_r) && !$past(rst_all) |-> $past(both_seen))
      else $error("fine code applied from one half");
   pix_update_a: assert property (
      $changed(pix_r) && !$past(rst_all) |-> $past(take))
      else $error("pixel word changed without a take");

   // serial port checks
   wire [3:0] chk_coarse = wr_data[3:0];
   wire [1:0] chk_flo = wr_data[1:0];
   // a word ended with the wrong number of bits
   sequence s_short_word;
      load_rise && (bitcnt_r != 5'(SER_BITS)) && !rst_all;
   endsequence
   // one half of the fine code written while the other is still missing
   sequence s_fine_half;
      ((wr_fhi && !lo_seen_r) || (wr_flo && !hi_seen_r)) && !rst_all;
   endsequence
   // the low half arriving after the high half
   sequence s_fine_second;
      wr_flo && hi_seen_r && !rst_all;
   endsequence
   // rejected words and lone halves leave the codes alone
   short_word_a: assert property (
      s_short_word |=> $stable(coarse_r) && $stable(fine_r))
      else $error("partial serial word was committed");
   fine_wait_a: assert property (
      s_fine_half |=> $stable(fine_r))
      else $error("fine code applied before both halves");
   // the joined code is the staged high half over the new low half
   fine_join_a: assert property (
      s_fine_second |=> fine_r == {$past(fhi_stage_r), $past(chk_flo)})
      else $error("fine code halves joined wrongly");
   // only d3:d0 of a coarse write are kept
   coarse_load_a: assert property (
      wr_coarse && !rst_all |=> coarse_r == $past(chk_coarse))
      else $error("coarse code not loaded");
   // the reset pulse follows its commit by one cycle
   soft_pulse_a: assert property (
      wr_reset |=> soft_rst_r)
      else $error("chip reset write gave no pulse");

   // phase and output checks
   dc_needs_video_a: assert property (
      dc_r |-> video_ph_r)
      else $error("dc restore outside the video phase");
   // with the clamp option low the cal pin, gated by the video phase, drives the restore switch
   cal_clamp_a: assert property (
      !clock_r[CK_CLAMP_OPT] && !rst_all
      |=> dc_r == (video_ph_r && $past(cal_act)))
      else $error("cal gate did not clamp in cal-only mode");
   // a fall with room must always reach the buffer
   video_push_a: assert property (
      video_fall && fifo_in_rdy && !rst_all |=> fifo_out_vld)
      else $error("video fall did not load the buffer");
   // a word may only leave the output register when it is taken
   pix_hold_a: assert property (
      pix_vld_r && !pixel_ready && !rst_all |=> pix_vld_r && $stable(pix_r))
      else $error("pixel word lost before it was taken");
endmodule : csoc_top
`default_nettype wire

/* File: testbench/csoc_partner.sv */
/*
 timing generator model: three wire serial writer and pixel strobes.
 assumes the clock of the block; the bench calls its tasks.
*/
`default_nettype none
module csoc_partner (
   input wire logic clk, // system clock
   output logic serial_clk, // shift clock, still outside words
   output logic serial_load_n, // latch, idle high
   output logic serial_data_in, // serial data
   output logic black_sample_strobe, // black strobe pin
   output logic video_sample_strobe, // video strobe pin
   output logic clamp_strobe, // clamp strobe pin
   output logic cal_strobe // calibration strobe pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] pol; // active levels: black, video, clamp
   // idle levels at time zero
   initial begin
      pol = 3'h0;
      serial_clk = 1'b0;
      serial_load_n = 1'b1;
      serial_data_in = 1'b0;
      black_sample_strobe = 1'b1;
      video_sample_strobe = 1'b1;
      clamp_strobe = 1'b1;
      cal_strobe = 1'b1; // cal stays inactive, active low
   end
   // wait n edges, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   // shift the top n bits, msb first, each half period 4 clocks
   task automatic send(input logic [11:0] word, input int n);
      serial_load_n = 1'b0;
      tick(4);
      for (int i = 11; i > 11 - n; i--) begin
         serial_data_in = word[i];
         tick(4);
         serial_clk = 1'b1;
         tick(4);
         serial_clk = 1'b0;
      end
      tick(4);
      serial_load_n = 1'b1;
      serial_data_in = ~serial_data_in; // released line, not the last bit
      tick(8);
   endtask : send
   // active or idle levels through the programmed polarities
   task automatic pins(input logic b, input logic v, input logic c);
      black_sample_strobe = b ~^ pol[2];
      video_sample_strobe = v ~^ pol[1];
      clamp_strobe = c ~^ pol[0];
   endtask : pins
   // one pixel placed on the ccd waveform: black, then video, then hold
   task automatic pixel(input logic c);
      pins(1'b1, 1'b0, 1'b0);
      tick(6);
      pins(1'b0, 1'b0, 1'b0);
      tick(2);
      pins(1'b0, 1'b1, c);
      tick(6);
      pins(1'b0, 1'b0, 1'b0);
      tick(8);
   endtask : pixel
   // calibration gate at the active low level it has after reset
   task automatic cal(input logic a);
      cal_strobe = ~a;
   endtask : cal
endmodule : csoc_partner
`default_nettype wire

/* File: testbench/csoc_top_test.sv */
/*
 self-checking bench of the sample and offset control block.
 assumes the partner model drives all pins; adc_code comes from here.
*/
`default_nettype none
module csoc_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   import csoc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [PIX_W-1:0] adc_code = '0;
   logic pixel_ready = 1'b0;
   wire serial_clk, serial_load_n, serial_data_in;
   wire black_sample_strobe, video_sample_strobe, clamp_strobe, cal_strobe;
   logic [PIX_W-1:0] pixel_out;
   logic [PIX_W-1:0] first_word;
   logic [9:0] fine_offset_code;
   logic [3:0] coarse_offset_code;
   logic pixel_valid, fifo_ready, black_phase, video_phase, dc_restore;
   logic reset_noise_reject, cal_active, power_down_bit, outputs_enable;
   logic rej_seen, dc_seen;
   int fail_count = 0;
   int check_count = 0;
   int taken = 0;
   // 40 mhz clock
   always #12.5 clk = ~clk;
   csoc_top csoc_top_inst (.clk, .sys_rst, .serial_clk, .serial_load_n,
      .serial_data_in, .black_sample_strobe, .video_sample_strobe,
      .clamp_strobe, .cal_strobe, .adc_code, .pixel_ready, .pixel_out,
      .pixel_valid, .fifo_ready, .black_phase, .video_phase, .dc_restore,
      .reset_noise_reject, .cal_active, .fine_offset_code,
      .coarse_offset_code, .power_down_bit, .outputs_enable);
   csoc_partner csoc_partner_inst (.clk, .serial_clk, .serial_load_n,
      .serial_data_in, .black_sample_strobe, .video_sample_strobe,
      .clamp_strobe, .cal_strobe);
   // watch reject and restore pulses, count words taken
   always @(posedge clk) begin
      if (reset_noise_reject === 1'b1) rej_seen <= 1'b1;
      if (dc_restore === 1'b1) dc_seen <= 1'b1;
      if (pixel_valid === 1'b1 && pixel_ready === 1'b1) begin
         if (taken == 0) first_word <= pixel_out;
         taken <= taken + 1;
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      csoc_partner_inst.send({a, d}, 12);
   endtask : wr
   task automatic drain(input int n);
      pixel_ready = 1'b1;
      csoc_partner_inst.tick(n);
      pixel_ready = 1'b0;
      csoc_partner_inst.tick(2);
   endtask : drain
   // one pixel with phase checks while the strobes are active
   task automatic pix(input logic c, input logic [9:0] code);
      adc_code = code;
      rej_seen = 1'b0;
      dc_seen = 1'b0;
      fork
         csoc_partner_inst.pixel(c);
         begin
            csoc_partner_inst.tick(5);
            check(16'(black_phase), 16'h1);
            check(16'(dc_restore), 16'h0);
            csoc_partner_inst.tick(7);
            check(16'(video_phase), 16'h1);
            check(16'(black_phase), 16'h0);
         end
      join
   endtask : pix
   // watchdog, about two and a half times the expected run
   initial begin
      #100000;
      fail_count++;
      results();
   end
   initial begin
      repeat (3) @(posedge clk);
      #2 sys_rst = 1'b0;
      csoc_partner_inst.tick(2);
      check(16'(fine_offset_code), 16'h0);
      check(16'(coarse_offset_code), 16'h0);
      check(16'(outputs_enable), 16'h1);
      check(16'(cal_active), 16'h0);
      wr(ADDR_COARSE, 8'hfb);
      check(16'(coarse_offset_code), 16'hb);
      wr(ADDR_FINE_HIGH, 8'hff);
      check(16'(fine_offset_code), 16'h0);
      wr(ADDR_FINE_LOW, 8'hfd);
      check(16'(fine_offset_code), 16'h3fd);
      wr(4'h9, 8'h00);
      check(16'(coarse_offset_code), 16'hb);
      csoc_partner_inst.send({ADDR_COARSE, 8'h05}, 11);
      check(16'(coarse_offset_code), 16'hb);
      wr(ADDR_CONTROL, 8'h03);
      check(16'(power_down_bit), 16'h1);
      check(16'(coarse_offset_code), 16'hb);
      wr(ADDR_CONTROL, 8'h01);
      check(16'(power_down_bit), 16'h0);
      check(16'(fine_offset_code), 16'h3fd);
      // default polarities, reject switch held closed
      pix(1'b1, 10'h2a5);
      check(16'(rej_seen), 16'h0);
      check(16'(dc_seen), 16'h1);
      check(16'(pixel_valid), 16'h1);
      check(16'(pixel_out), 16'h2a5);
      // active high strobes, reject clocked
      csoc_partner_inst.pol = 3'h7;
      csoc_partner_inst.pins(1'b0, 1'b0, 1'b0);
      wr(ADDR_CLOCK, 8'h5e);
      drain(6);
      pix(1'b0, 10'h15a);
      check(16'(rej_seen), 16'h1);
      check(16'(reset_noise_reject), 16'h0);
      check(16'(dc_seen), 16'h0);
      check(16'(pixel_out), 16'h15a);
      // chip reset restores defaults
      csoc_partner_inst.pol = 3'h0;
      csoc_partner_inst.pins(1'b0, 1'b0, 1'b0);
      wr(ADDR_CHIP_RESET, 8'h01);
      check(16'(coarse_offset_code), 16'h0);
      check(16'(fine_offset_code), 16'h0);
      check(16'(outputs_enable), 16'h1);
      drain(6);
      taken = 0;
      // buffer plus output word hold one more than the depth; last is lost
      for (int i = 0; i <= FIFO_D + 1; i++) pix(1'b0, 10'(i + 1));
      check(16'(fifo_ready), 16'h0);
      drain(FIFO_D * 3);
      check(16'(taken), 16'(FIFO_D + 1));
      check(16'(first_word), 16'h1);
      check(16'(pixel_out), 16'(FIFO_D + 1));
      check(16'(pixel_valid), 16'h0);
      check(16'(fifo_ready), 16'h1);
      // cal only mode: the cal gate also clamps, reject stays closed
      wr(ADDR_CLOCK, 8'h00);
      csoc_partner_inst.cal(1'b1);
      csoc_partner_inst.tick(4);
      check(16'(cal_active), 16'h1);
      pix(1'b0, 10'h0c3);
      check(16'(dc_seen), 16'h1);
      check(16'(rej_seen), 16'h0);
      check(16'(pixel_out), 16'h0c3);
      csoc_partner_inst.cal(1'b0);
      csoc_partner_inst.tick(4);
      check(16'(cal_active), 16'h0);
      results();
   end
endmodule : csoc_top_test
`default_nettype wire
